//--- pkg/wwt_consts.vh
// Register map, field positions, reset values and timing constants of the watchdog
`ifndef WWT_CONSTS_VH
`define WWT_CONSTS_VH

// Register word offsets (byte addresses)
`define WWT_OFS_MODE    5'h00
`define WWT_OFS_TIMEOUT 5'h04
`define WWT_OFS_FEED    5'h08
`define WWT_OFS_COUNT   5'h0c
`define WWT_OFS_WARN    5'h10
`define WWT_OFS_WINDOW  5'h14
`define WWT_OFS_STATUS  5'h18
`define WWT_OFS_MASK    5'h1c

// Mode register fields
`define WWT_MODE_EN  0
`define WWT_MODE_INT 1
`define WWT_MODE_WIN 2

// Status and mask register fields
`define WWT_ST_TOUT 0
`define WWT_ST_WARN 1
`define WWT_ST_FERR 2
`define WWT_ST_WDRS 3

// Feed keys
`define WWT_KEY1 32'h0000_00aa
`define WWT_KEY2 32'h0000_0055

// Reset values
`define WWT_RST_TIMEOUT 24'hff_ffff
`define WWT_RST_WARN    24'h00_0000
`define WWT_RST_WINDOW  24'hff_ffff

// Smallest time-out value: 256 counts down to zero
`define WWT_MIN_TIMEOUT 24'h00_00ff
// Prescaler divides the oscillator by four
`define WWT_PRESC_LAST  2'h3

`endif

//--- design/wwt_windowed_watchdog.v
// Windowed watchdog with AHB-Lite register slave, prescaler, feed checking and interrupt
// What this block does
// R1: While enabled, an unreloaded time-out resets the whole chip, or interrupts in interrupt mode.
// R2: While enabled in window mode, a feed counts only between the minimum and maximum time.
// R3: When enabled, a warning interrupt is raised at a programmable count.
// R4: Software may only switch it on; reset or watchdog event switches it off.
// R5: While enabled, a bad feed sequence resets the chip, or interrupts in interrupt mode.
// R6: A flag records that the last chip reset came from the watchdog.
// R7: The time-out counter is 24 bits, behind an internal prescaler.
// R8: Period runs from 256x4 to 2^24x4 oscillator periods, in steps of four.
// R9: Counting is paced by the watchdog oscillator, not the system clock.
// R10: A feed is two key writes in a row; anything between is an error.
// R11: A valid feed reloads the counter; it counts down; zero means time-out.
`include "wwt_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module wwt_windowed_watchdog (
  // System clock and resets
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        por_resetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Watchdog oscillator pin
  input  wire        watchdog_oscillator,
  // Results
  output reg         chip_reset_req,
  output wire        irq
);

  // Bus state
  reg        act_ff;
  reg        wr_ff;
  reg  [4:0] waddr_ff;
  // Oscillator synchroniser and prescaler
  reg        osc_s1_ff;
  reg        osc_s2_ff;
  reg        osc_s3_ff;
  reg  [1:0] presc_ff;
  // Control and status
  reg  [2:0]  mode_ff;
  reg  [23:0] tout_ff;
  reg  [23:0] warn_ff;
  reg  [23:0] win_ff;
  reg  [23:0] cnt_ff;
  reg  [2:0]  stat_ff;
  reg         wdrs_ff;
  reg  [3:0]  mask_ff;
  reg         armed_ff;

  // Decoded events and next values
  wire        acc;
  wire        osc_rise;
  wire        tick;
  wire        wr_now;
  wire        en;
  reg         nxt_armed;
  reg         feed_try;
  reg         seq_err;
  wire        win_ok;
  wire        feed_ok;
  wire        feed_err;
  wire        tout_ev;
  wire        warn_ev;
  wire        fail_ev;
  wire [3:0]  st_all;
  wire [3:0]  w1c;
  reg  [31:0] nxt_rdata;

  // Zero-wait slave that always answers OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign acc       = hsel & htrans[1] & hready;
  assign en        = mode_ff[`WWT_MODE_EN];
  assign wr_now    = act_ff & wr_ff;

  // Capture the address phase for the following data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_ff   <= 1'b0;
      wr_ff    <= 1'b0;
      waddr_ff <= 5'h00;
    end else begin
      act_ff   <= acc;
      wr_ff    <= acc & hwrite;
      waddr_ff <= haddr[4:0];
    end
  end

  // Read data is chosen in the address phase so it stands in the data phase
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (haddr[4:0])
      `WWT_OFS_MODE:    nxt_rdata = {29'h0, mode_ff};
      `WWT_OFS_TIMEOUT: nxt_rdata = {8'h00, tout_ff};
      `WWT_OFS_COUNT:   nxt_rdata = {8'h00, cnt_ff};
      `WWT_OFS_WARN:    nxt_rdata = {8'h00, warn_ff};
      `WWT_OFS_WINDOW:  nxt_rdata = {8'h00, win_ff};
      `WWT_OFS_STATUS:  nxt_rdata = {28'h000_0000, st_all};
      `WWT_OFS_MASK:    nxt_rdata = {28'h000_0000, mask_ff};
      default:          nxt_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc & ~hwrite) begin
      hrdata <= nxt_rdata;
    end
  end

  // Oscillator pin crosses into hclk through two flops; third one finds the edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_s1_ff <= 1'b0;
      osc_s2_ff <= 1'b0;
      osc_s3_ff <= 1'b0;
    end else begin
      osc_s1_ff <= watchdog_oscillator;
      osc_s2_ff <= osc_s1_ff;
      osc_s3_ff <= osc_s2_ff;
    end
  end

  assign osc_rise = osc_s2_ff & ~osc_s3_ff; // R9
  assign tick     = osc_rise & (presc_ff == `WWT_PRESC_LAST) & en; // R7

  // Fixed divide-by-four prescaler, restarted by each good feed
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_ff <= 2'h0;
    end else if (feed_ok | ~en) begin
      presc_ff <= 2'h0;
    end else if (osc_rise) begin
      presc_ff <= presc_ff + 2'h1; // R8
    end
  end

  // Feed sequence: key one arms, key two fires, anything else in between fails
  always @* begin
    nxt_armed = armed_ff;
    feed_try  = 1'b0;
    seq_err   = 1'b0;
    if (act_ff) begin
      if (wr_ff && (waddr_ff == `WWT_OFS_FEED)) begin
        nxt_armed = 1'b0;
        if (!armed_ff && (hwdata == `WWT_KEY1)) begin
          nxt_armed = 1'b1; // R10
        end else if (armed_ff && (hwdata == `WWT_KEY2)) begin
          feed_try = 1'b1; // R10
        end else begin
          seq_err = 1'b1; // R10
        end
      end else if (armed_ff) begin
        nxt_armed = 1'b0;
        seq_err   = 1'b1; // R10
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_ff <= 1'b0;
    end else begin
      armed_ff <= nxt_armed;
    end
  end

  // Too early a feed in window mode is refused while enabled; late is already a time-out
  assign win_ok   = ~mode_ff[`WWT_MODE_WIN] | (cnt_ff <= win_ff); // R2
  assign feed_ok  = feed_try & (win_ok | ~en);
  assign feed_err = en & (seq_err | (feed_try & ~win_ok)); // R5
  assign tout_ev  = tick & (cnt_ff == 24'h00_0000); // R11
  assign warn_ev  = tick & (cnt_ff == warn_ff); // R3
  assign fail_ev  = tout_ev | feed_err;

  // Down counter reloads on a good feed and counts once per prescaled tick
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= `WWT_RST_TIMEOUT;
    end else if (feed_ok) begin
      cnt_ff <= tout_ff; // R11
    end else if (tick && (cnt_ff != 24'h00_0000)) begin
      cnt_ff <= cnt_ff - 24'h00_0001; // R11
    end
  end

  // Chip reset request: one-cycle pulse, unless interrupt mode takes the event
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chip_reset_req <= 1'b0;
    end else begin
      chip_reset_req <= fail_ev & ~mode_ff[`WWT_MODE_INT]; // R1 R5
    end
  end

  // Mode: enable is set-only and the other bits freeze once it is set
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff <= 3'h0;
    end else begin
      if (wr_now && (waddr_ff == `WWT_OFS_MODE)) begin
        if (!en) begin
          mode_ff[`WWT_MODE_INT] <= hwdata[`WWT_MODE_INT];
          mode_ff[`WWT_MODE_WIN] <= hwdata[`WWT_MODE_WIN];
        end
        if (hwdata[`WWT_MODE_EN]) begin
          mode_ff[`WWT_MODE_EN] <= 1'b1; // R4
        end
      end
      // A time-out or feed error switches it off, and wins over a write
      if (fail_ev) begin
        mode_ff[`WWT_MODE_EN] <= 1'b0; // R4
      end
    end
  end

  // Time-out, warning and window values; a short time-out is raised to the floor
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tout_ff <= `WWT_RST_TIMEOUT;
      warn_ff <= `WWT_RST_WARN;
      win_ff  <= `WWT_RST_WINDOW;
      mask_ff <= 4'h0;
    end else if (wr_now) begin
      if (waddr_ff == `WWT_OFS_TIMEOUT) begin
        if (hwdata[23:0] < `WWT_MIN_TIMEOUT) begin
          tout_ff <= `WWT_MIN_TIMEOUT; // R8
        end else begin
          tout_ff <= hwdata[23:0]; // R8
        end
      end
      if (waddr_ff == `WWT_OFS_WARN) begin
        warn_ff <= hwdata[23:0];
      end
      if (waddr_ff == `WWT_OFS_WINDOW) begin
        win_ff <= hwdata[23:0];
      end
      if (waddr_ff == `WWT_OFS_MASK) begin
        mask_ff <= hwdata[3:0];
      end
    end
  end

  // Sticky status, write one to clear; a new event in the same cycle wins
  assign w1c = (wr_now && (waddr_ff == `WWT_OFS_STATUS)) ? hwdata[3:0] : 4'h0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_ff <= 3'h0;
    end else begin
      stat_ff[`WWT_ST_TOUT] <= (stat_ff[`WWT_ST_TOUT] & ~w1c[`WWT_ST_TOUT]) | tout_ev;
      stat_ff[`WWT_ST_WARN] <= (stat_ff[`WWT_ST_WARN] & ~w1c[`WWT_ST_WARN]) | warn_ev; // R3
      stat_ff[`WWT_ST_FERR] <= (stat_ff[`WWT_ST_FERR] & ~w1c[`WWT_ST_FERR]) | feed_err; // R5
    end
  end

  // Reset-cause flag lives on power-on reset only, so it outlasts the chip reset
  always @(posedge hclk or negedge por_resetn) begin
    if (!por_resetn) begin
      wdrs_ff <= 1'b0;
    end else begin
      wdrs_ff <= (wdrs_ff & ~w1c[`WWT_ST_WDRS]) | chip_reset_req; // R6
    end
  end

  assign st_all = {wdrs_ff, stat_ff};

  // Level interrupt while any unmasked status bit is set
  assign irq = |(st_all & mask_ff);

endmodule // wwt_windowed_watchdog

`default_nettype wire

//--- testbench/wwt_assertions.sv
// Port-level assertion checker for the windowed watchdog
`timescale 1ns/1ns
`default_nettype none
module wwt_checker (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // Results
  input wire logic        chip_reset_req,
  input wire logic        irq
);
  wire logic       rd = hsel && htrans[1] && hready && !hwrite;
  logic            wr_ff;
  logic            en_ff;
  logic            msk_ff;
  logic [4:0]      wa_ff;
  // Remember enabling and unmasking writes; without them no event may reach the pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff  <= 1'b0;
      wa_ff  <= 5'h00;
      en_ff  <= 1'b0;
      msk_ff <= 1'b0;
    end else begin
      wr_ff <= hsel && htrans[1] && hready && hwrite;
      wa_ff <= haddr[4:0];
      if (wr_ff && wa_ff == 5'h00 && hwdata[0]) en_ff <= 1'b1;
      if (wr_ff && wa_ff == 5'h1c && |hwdata[3:0]) msk_ff <= 1'b1;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_pulse_one: assert property (chip_reset_req |=> !chip_reset_req)
    else $error("reset request wider than one cycle");
  chk_no_en_quiet: assert property (!en_ff |-> !chip_reset_req)
    else $error("reset request while never enabled");
  chk_irq_masked: assert property (!msk_ff |-> !irq)
    else $error("interrupt with every status bit masked");
  chk_feed_rdzero: assert property (rd && haddr[4:0] == 5'h08 |=> hrdata == 32'h0)
    else $error("feed register read not zero");
  chk_count_width: assert property (rd && haddr[4:0] inside {5'h04, 5'h0c, 5'h10, 5'h14}
    |=> hrdata[31:24] == 8'h00)
    else $error("timer field wider than 24 bits");
  chk_mode_width: assert property (rd && haddr[4:0] == 5'h00 |=> hrdata[31:3] == 29'h0)
    else $error("mode upper bits not zero");
  chk_stat_width: assert property (rd && haddr[4:0] == 5'h18 |=> hrdata[31:4] == 28'h0)
    else $error("status upper bits not zero");
  chk_read_hold: assert property (!rd |=> $stable(hrdata))
    else $error("read data changed without a read");
  cover property (chip_reset_req);
  cover property (irq);
  cover property (rd && haddr[4:0] == 5'h14);
endmodule // wwt_checker
`default_nettype wire

//--- testbench/tb_windowed_watchdog_timer.sv
// Self-checking testbench for the windowed watchdog
`timescale 1ns/1ns
`default_nettype none
`define WWT_CHK(a, b) begin \
  n_compared++; \
  if ((a) !== (b)) begin \
    mismatches++; \
    $display("[FAIL] %0t got %h want %h", $time, (a), (b)); \
  end \
end
module tb_windowed_watchdog_timer;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        por_resetn = 1'b0;
  logic        hwrite = 1'b0;
  logic        osc = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  ph = 3'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] d;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         rst_req;
  wire         irq;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n;
  wwt_windowed_watchdog dut_u (.hclk(hclk), .hresetn(hresetn), .por_resetn(por_resetn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .watchdog_oscillator(osc), .chip_reset_req(rst_req), .irq(irq));
  always #2 hclk = ~hclk;
  // Oscillator period is six bus clocks, so one prescaled tick takes 24
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    ph <= (ph == 3'h2) ? 3'h0 : ph + 3'h1;
    if (ph == 3'h2) osc <= ~osc;
    if (cyc == 30000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One single word transfer; read data lands in d
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v);
    htrans <= 2'h2;
    haddr <= {27'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= v;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `WWT_CHK(d, e)
  endtask
  // Sampled at the falling edge so registered pulses have settled
  task automatic wait_req(input int lim);
    n = 0;
    while (rst_req !== 1'b1 && n < lim) begin
      @(negedge hclk);
      n++;
    end
    @(posedge hclk);
  endtask
  task automatic t_reset();
    rc(5'h00, 32'h0);
    rc(5'h04, 32'hffffff);
    rc(5'h08, 32'h0);
    rc(5'h0c, 32'hffffff);
    rc(5'h10, 32'h0);
    rc(5'h14, 32'hffffff);
    rc(5'h18, 32'h0);
    rc(5'h1c, 32'h0);
    $display("reset values done");
  endtask
  task automatic t_timeout();
    bus(1'b1, 5'h04, 32'h10);
    rc(5'h04, 32'hff);
    bus(1'b1, 5'h08, 32'haa);
    bus(1'b1, 5'h08, 32'h55);
    bus(1'b1, 5'h00, 32'h1);
    bus(1'b1, 5'h00, 32'h0);
    rc(5'h00, 32'h1);
    repeat (48) @(posedge hclk);
    bus(1'b0, 5'h0c, 32'h0);
    `WWT_CHK(d[23:0] < 24'hff, 1'b1)
    wait_req(8000);
    `WWT_CHK(n > 5990 && n < 6200, 1'b1)
    rc(5'h18, 32'hb);
    rc(5'h00, 32'h0);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(5'h18, 32'h8);
    $display("time-out done");
  endtask
  task automatic t_ferr();
    bus(1'b1, 5'h18, 32'hf);
    bus(1'b1, 5'h1c, 32'hf);
    bus(1'b1, 5'h00, 32'h3);
    bus(1'b1, 5'h08, 32'haa);
    bus(1'b0, 5'h0c, 32'h0);
    rc(5'h18, 32'h4);
    wait_req(8);
    `WWT_CHK(irq, 1'b1)
    `WWT_CHK(n, 8)
    bus(1'b1, 5'h18, 32'h4);
    wait_req(2);
    `WWT_CHK(irq, 1'b0)
    bus(1'b1, 5'h00, 32'h1);
    bus(1'b1, 5'h08, 32'h55);
    wait_req(8);
    `WWT_CHK(n < 8, 1'b1)
    $display("feed error done");
  endtask
  task automatic t_window();
    bus(1'b1, 5'h18, 32'hf);
    bus(1'b1, 5'h04, 32'hff);
    bus(1'b1, 5'h10, 32'h80);
    bus(1'b1, 5'h14, 32'h10);
    bus(1'b1, 5'h00, 32'h6);
    bus(1'b1, 5'h08, 32'haa);
    bus(1'b1, 5'h08, 32'h55);
    bus(1'b1, 5'h00, 32'h7);
    bus(1'b1, 5'h08, 32'haa);
    bus(1'b1, 5'h08, 32'h55);
    rc(5'h18, 32'h4);
    bus(1'b1, 5'h18, 32'h4);
    bus(1'b1, 5'h08, 32'haa);
    bus(1'b1, 5'h08, 32'h55);
    bus(1'b1, 5'h00, 32'h7);
    repeat (5900) @(posedge hclk);
    bus(1'b1, 5'h08, 32'haa);
    bus(1'b1, 5'h08, 32'h55);
    rc(5'h18, 32'h2);
    bus(1'b0, 5'h0c, 32'h0);
    `WWT_CHK(d[23:0] > 24'hf0, 1'b1)
    $display("window done");
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    por_resetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_timeout();
    t_ferr();
    t_window();
    test_done();
  end
endmodule // tb_windowed_watchdog_timer
bind wwt_windowed_watchdog wwt_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hrdata(hrdata), .chip_reset_req(chip_reset_req), .irq(irq));
`default_nettype wire
